//--- ims_host_model.sv
// host model: serial clock source and frame receiver
`timescale 1ns/1ps
module ims_host_model (
  // clock and reset
  input  wire logic        clock,
  input  wire logic        rst_n,
  // serial clock control and level
  input  wire logic        hold_high,
  output logic             serial_clock_level,
  // serial data from the device
  input  wire logic        sdo,
  input  wire logic        frame_active,
  // last received frame
  output logic [79:0]      frame_bits,
  output logic [6:0]       frame_len,
  output logic [7:0]       frame_total
);
  logic [79:0] shift;
  logic [6:0]  count;
  // toggles every cycle; holding it high trips the stuck-clock timer
  always @(posedge clock or negedge rst_n) begin
    if (!rst_n) serial_clock_level <= 1'b0;
    else serial_clock_level <= hold_high | ~serial_clock_level;
  end
  always @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      shift <= 80'h0;
      count <= 7'h00;
      frame_bits <= 80'h0;
      frame_len <= 7'h00;
      frame_total <= 8'h00;
    end else if (frame_active) begin
      shift <= {shift[78:0], sdo};
      count <= count + 7'h01;
    end else if (count != 7'h00) begin
      frame_bits <= shift;
      frame_len <= count;
      frame_total <= frame_total + 8'h01;
      count <= 7'h00;
    end
  end
endmodule // ims_host_model

//--- ims_mode_config.v
// interface mode selection, strap latching and two-wire framer with result fifo
`timescale 1ns/1ps
`include "ims_regs.vh"

module ims_fifo #(
  parameter WIDTH = 64,
  parameter DEPTH = 16,
  parameter AW    = 4
) (
  // clock and reset
  input  wire             clock,
  input  wire             rst_n,
  // synchronous flush
  input  wire             flush,
  // fill side
  input  wire             in_valid,
  output reg              in_ready,
  input  wire [WIDTH-1:0] in_data,
  // drain side
  output wire             out_valid,
  input  wire             out_ready,
  output wire [WIDTH-1:0] out_data
);
  reg [WIDTH-1:0] mem [0:DEPTH-1];
  reg [AW-1:0]    rd_ptr;
  reg [AW-1:0]    wr_ptr;
  reg [AW:0]      count;
  wire            push;
  wire            pop;

  assign push      = in_valid && in_ready;
  assign pop       = out_valid && out_ready;
  assign out_valid = (count != {(AW+1){1'b0}});
  assign out_data  = mem[rd_ptr];

  always @(posedge clock) begin
    if (push) begin
      mem[wr_ptr] <= in_data;
    end
  end

  always @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      rd_ptr   <= {AW{1'b0}};
      wr_ptr   <= {AW{1'b0}};
      count    <= {(AW+1){1'b0}};
      in_ready <= 1'b0;
    end else if (flush) begin
      rd_ptr   <= {AW{1'b0}};
      wr_ptr   <= {AW{1'b0}};
      count    <= {(AW+1){1'b0}};
      in_ready <= 1'b0;
    end else begin
      if (push) begin
        wr_ptr <= (wr_ptr == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : wr_ptr + 1'b1;
      end
      if (pop) begin
        rd_ptr <= (rd_ptr == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : rd_ptr + 1'b1;
      end
      if (push && !pop) begin
        count    <= count + 1'b1;
        in_ready <= (count + 1'b1) < DEPTH[AW:0];
      end else if (pop && !push) begin
        count    <= count - 1'b1;
        in_ready <= 1'b1;
      end else begin
        in_ready <= count < DEPTH[AW:0];
      end
    end
  end
endmodule // ims_fifo

module ims_mode_config #(
  parameter FIFO_DEPTH = `IMS_FIFO_DEPTH
) (
  // clock and power-on reset
  input  wire        clock,
  input  wire        rst_n,
  // external clock selection bit, written by the configuration side
  input  wire        ext_clk_sel_write,
  input  wire        ext_clk_sel_value,
  output reg         external_clock_select,
  // mode and strap pins
  input  wire        interface_select_pin,
  input  wire        reset_pin_n,
  input  wire        sdi_pin,
  input  wire        cs_pin_n,
  input  wire        oscillator_input_pin,
  input  wire        conversion_done_pin_in,
  output reg         conversion_done_pin_out,
  output reg         conversion_done_pin_oe,
  // serial clock level, watched for the stuck-high watchdog
  input  wire        serial_clock_level,
  // spi-side settings and data ready, used in spi mode
  input  wire [1:0]  spi_ratio_code,
  input  wire        spi_boost,
  input  wire [1:0]  spi_gain_code,
  input  wire        spi_done_n,
  // modulator outputs
  input  wire [1:0]  modulator_data,
  output reg  [1:0]  modulator_output_pins,
  output reg  [1:0]  modulator_output_oe,
  // conversion results: ch0, ch1, crc
  input  wire        result_valid,
  output wire        result_ready,
  input  wire [23:0] result_ch0,
  input  wire [23:0] result_ch1,
  input  wire [15:0] result_crc,
  // serial data output
  output reg         sdo,
  output reg         sdo_oe,
  // resulting configuration
  output reg         two_wire_mode,
  output reg         force_defaults,
  output reg  [1:0]  ratio_code,
  output reg  [9:0]  oversampling_ratio,
  output reg         boost_full,
  output reg  [1:0]  gain_code,
  output reg  [5:0]  ch0_gain,
  output reg  [1:0]  frame_count_bits,
  output reg         frame_active,
  output reg         core_reset
);
  localparam integer WATCH_INT    = `IMS_WATCH_CYCLES;
  localparam [8:0]   WATCH_CYCLES = WATCH_INT[8:0];

  reg  [`IMS_SY_WIDTH-1:0] pin_meta;
  reg  [`IMS_SY_WIDTH-1:0] pin_sync;
  reg                      in_reset;
  reg  [1:0]               por_wait;
  reg                      por_busy;
  reg                      mode;
  reg                      sel_prev;
  reg  [1:0]               strap_ratio;
  reg                      strap_boost;
  reg  [1:0]               strap_gain;
  reg  [8:0]               watch_cnt;
  reg                      watch_fire;
  reg  [79:0]              frame_sr;
  reg  [6:0]               bits_left;
  reg  [1:0]               frame_cnt;
  wire                     next_in_reset;
  wire                     hard_reset_req;
  wire                     fifo_valid;
  wire [63:0]              fifo_data;
  wire                     frame_start;
  wire [1:0]               eff_ratio;
  wire                     eff_boost;
  wire [1:0]               eff_gain;
  wire [15:0]              sync_word;

  function [9:0] ratio_value;
    input [1:0] code;
    begin
      case (code)
        2'h0:    ratio_value = 10'h040;
        2'h1:    ratio_value = 10'h080;
        2'h2:    ratio_value = 10'h100;
        default: ratio_value = 10'h200;
      endcase
    end
  endfunction

  function [5:0] gain_value;
    input [1:0] code;
    begin
      case (code)
        2'h0:    gain_value = 6'h01;
        2'h1:    gain_value = 6'h08;
        2'h2:    gain_value = 6'h10;
        default: gain_value = 6'h20;
      endcase
    end
  endfunction

  // every pin passes two flops before any logic reads it
  always @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      pin_meta <= {`IMS_SY_WIDTH{1'b0}};
      pin_sync <= {`IMS_SY_WIDTH{1'b0}};
    end else begin
      pin_meta <= {serial_clock_level, conversion_done_pin_in, oscillator_input_pin,
                   cs_pin_n, sdi_pin, reset_pin_n, interface_select_pin};
      pin_sync <= pin_meta;
    end
  end

  // hard reset pin only exists in spi mode; in two-wire it is a ratio strap
  // ignored until power-on has latched a mode: a low ratio strap must not hold reset forever
  assign hard_reset_req = (mode == `IMS_MODE_SPI) && !por_busy && !pin_sync[`IMS_SY_RESET];
  assign next_in_reset  = hard_reset_req || watch_fire || (por_wait != 2'h0);

  // qualifying reset state; power-on starts inside it so the first release captures the mode
  always @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      in_reset   <= 1'b1;
      mode       <= `IMS_MODE_RST;
      core_reset <= 1'b1;
      por_wait   <= `IMS_POR_WAIT;
      por_busy   <= 1'b1;
    end else begin
      in_reset   <= next_in_reset;
      core_reset <= next_in_reset;
      // power-on exit waits until the synchroniser holds real pin levels
      if (por_wait != 2'h0) begin
        por_wait <= por_wait - 2'h1;
      end
      if (in_reset && !next_in_reset) begin
        por_busy <= 1'b0;
        // a floating select pin is pulled low and lands on spi
        mode <= external_clock_select && pin_sync[`IMS_SY_SELECT];
      end
    end
  end

  // external clock select bit returns to its set state on every qualifying reset
  always @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      external_clock_select <= `IMS_EXT_CLK_SEL_RST;
    end else if (in_reset) begin
      external_clock_select <= `IMS_EXT_CLK_SEL_RST;
    end else if (ext_clk_sel_write && !two_wire_mode) begin
      external_clock_select <= ext_clk_sel_value;
    end
  end

  // strap capture on the select rising edge; sel_prev cleared so a reset re-arms it
  always @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      sel_prev    <= 1'b0;
      strap_ratio <= `IMS_RATIO_RST;
      strap_boost <= `IMS_BOOST_RST;
      strap_gain  <= `IMS_GAIN_RST;
    end else if (in_reset) begin
      sel_prev    <= 1'b0;
      strap_ratio <= `IMS_RATIO_RST;
      strap_boost <= `IMS_BOOST_RST;
      strap_gain  <= `IMS_GAIN_RST;
    end else begin
      sel_prev <= pin_sync[`IMS_SY_SELECT];
      if (mode == `IMS_MODE_TWO_WIRE && pin_sync[`IMS_SY_SELECT] && !sel_prev) begin
        strap_ratio <= {pin_sync[`IMS_SY_SDI], pin_sync[`IMS_SY_RESET]};
        strap_boost <= pin_sync[`IMS_SY_CS];
        strap_gain  <= {pin_sync[`IMS_SY_DONE], pin_sync[`IMS_SY_OSCILLATOR_INPUT_PIN]};
      end
    end
  end

  assign eff_ratio = mode ? strap_ratio : spi_ratio_code;
  assign eff_boost = mode ? strap_boost : spi_boost;
  assign eff_gain  = mode ? strap_gain  : spi_gain_code;

  // settings driven out of flops
  always @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      two_wire_mode      <= `IMS_MODE_RST;
      force_defaults     <= 1'b0;
      ratio_code         <= `IMS_RATIO_RST;
      oversampling_ratio <= 10'h040;
      boost_full         <= `IMS_BOOST_RST;
      gain_code          <= `IMS_GAIN_RST;
      ch0_gain           <= 6'h01;
    end else begin
      two_wire_mode      <= mode;
      force_defaults     <= mode;
      ratio_code         <= eff_ratio;
      oversampling_ratio <= ratio_value(eff_ratio);
      boost_full         <= eff_boost;
      gain_code          <= eff_gain;
      ch0_gain           <= gain_value(eff_gain);
    end
  end

  // watchdog: counts while the serial clock stays high, low clears it
  always @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      watch_cnt  <= 9'h000;
      watch_fire <= 1'b0;
    end else if (mode != `IMS_MODE_TWO_WIRE || !pin_sync[`IMS_SY_SCK] || in_reset) begin
      watch_cnt  <= 9'h000;
      watch_fire <= 1'b0;
    end else if (watch_cnt >= WATCH_CYCLES - 9'h001) begin
      watch_fire <= 1'b1;
    end else begin
      watch_cnt <= watch_cnt + 9'h001;
    end
  end

  // result buffer; a full fifo stalls the result source through result_ready
  ims_fifo #(
    .WIDTH (`IMS_WORD_WIDTH),
    .DEPTH (FIFO_DEPTH),
    .AW    (4)
  ) u_fifo (
    .clock     (clock),
    .rst_n     (rst_n),
    .flush     (in_reset || !mode),
    .in_valid  (result_valid),
    .in_ready  (result_ready),
    .in_data   ({result_ch0, result_ch1, result_crc}),
    .out_valid (fifo_valid),
    .out_ready (frame_start),
    .out_data  (fifo_data)
  );

  // sync word: fixed byte then straps and frame count
  assign sync_word   = {`IMS_SYNC_BYTE, strap_ratio, strap_boost, strap_gain,
                        frame_cnt, 1'b0};
  assign frame_start = mode && !in_reset && (bits_left == 7'd0) && fifo_valid;

  // framer: one bit per clock, msb first
  always @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      frame_sr  <= 80'h0;
      bits_left <= 7'd0;
      frame_cnt <= `IMS_CNT_RST;
    end else if (in_reset || !mode) begin
      frame_sr  <= 80'h0;
      bits_left <= 7'd0;
      frame_cnt <= `IMS_CNT_RST;
    end else if (frame_start) begin
      if (strap_ratio == 2'h0) begin
        // short frame keeps the top 16 bits of each channel
        frame_sr  <= {sync_word, fifo_data[63:48], fifo_data[39:24], fifo_data[15:0], 16'h0};
        bits_left <= `IMS_FRAME_SHORT;
      end else begin
        frame_sr  <= {sync_word, fifo_data};
        bits_left <= `IMS_FRAME_LONG;
      end
      frame_cnt <= frame_cnt + 2'h1;
    end else if (bits_left != 7'd0) begin
      frame_sr  <= {frame_sr[78:0], 1'b0};
      bits_left <= bits_left - 7'd1;
    end
  end

  // pin drivers
  always @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      sdo                     <= 1'b0;
      sdo_oe                  <= 1'b0;
      frame_active            <= 1'b0;
      frame_count_bits        <= `IMS_CNT_RST;
      modulator_output_pins   <= 2'h0;
      modulator_output_oe     <= 2'h0;
      conversion_done_pin_out <= 1'b1;
      conversion_done_pin_oe  <= 1'b0;
    end else if (mode == `IMS_MODE_TWO_WIRE) begin
      sdo                     <= (bits_left != 7'd0) && frame_sr[79];
      sdo_oe                  <= 1'b1;
      frame_active            <= (bits_left != 7'd0);
      frame_count_bits        <= frame_cnt;
      modulator_output_pins   <= 2'h0;
      modulator_output_oe     <= 2'h0;
      conversion_done_pin_out <= 1'b1;
      conversion_done_pin_oe  <= 1'b0;
    end else begin
      // spi mode: serial output belongs to the spi engine elsewhere
      sdo                     <= 1'b0;
      sdo_oe                  <= 1'b0;
      frame_active            <= 1'b0;
      frame_count_bits        <= `IMS_CNT_RST;
      modulator_output_pins   <= modulator_data;
      modulator_output_oe     <= 2'h3;
      conversion_done_pin_out <= spi_done_n;
      conversion_done_pin_oe  <= !in_reset;
    end
  end
endmodule // ims_mode_config

//--- ims_mode_config_checker.sv
// concurrent checks on mode, strap and framer outputs
`timescale 1ns/1ps
module ims_mode_config_checker (
  // clock and reset
  input logic       clock,
  input logic       rst_n,
  // observed outputs
  input logic       two_wire_mode,
  input logic       core_reset,
  input logic       sdo,
  input logic       sdo_oe,
  input logic       frame_active,
  input logic [1:0] modulator_output_oe,
  input logic       conversion_done_pin_oe,
  input logic [1:0] ratio_code,
  input logic [9:0] oversampling_ratio,
  input logic [1:0] gain_code,
  input logic [5:0] ch0_gain
);
  logic [6:0] run_len;
  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_n);
  // cleared while idle; frames that touch without a gap are not measured
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) run_len <= 7'h00;
    else if (!frame_active) run_len <= 7'h00;
    else run_len <= run_len + 7'h01;
  end
  chk_mod_hiz: assert property (two_wire_mode |-> modulator_output_oe == 2'h0)
    else $error("modulator pins driven in two-wire mode");
  chk_sdo_driven: assert property (two_wire_mode |-> sdo_oe)
    else $error("serial output released in two-wire mode");
  chk_sdo_idle: assert property (two_wire_mode && !frame_active |-> !sdo)
    else $error("serial output high between frames");
  chk_spi_quiet: assert property (!two_wire_mode |-> !sdo_oe && !frame_active)
    else $error("two-wire output active in spi mode");
  chk_done_input: assert property (two_wire_mode |-> !conversion_done_pin_oe)
    else $error("done pin driven in two-wire mode");
  chk_ratio_map: assert property (oversampling_ratio == (10'h040 << ratio_code))
    else $error("ratio code maps to wrong value");
  chk_gain_map: assert property (ch0_gain == ((gain_code == 2'h0) ? 6'h01 : (6'h04 << gain_code)))
    else $error("gain code maps to wrong value");
  chk_frame_len: assert property ($fell(frame_active) |-> run_len == ((ratio_code == 2'h0) ? 7'h40 : 7'h50))
    else $error("frame length wrong");
  chk_mode_latch: assert property ($changed(two_wire_mode) |-> core_reset || $past(core_reset) || $past(core_reset, 2))
    else $error("mode changed outside a reset exit");
endmodule // ims_mode_config_checker

bind ims_mode_config ims_mode_config_checker chk_u (
  .clock(clock), .rst_n(rst_n), .two_wire_mode(two_wire_mode), .core_reset(core_reset),
  .sdo(sdo), .sdo_oe(sdo_oe), .frame_active(frame_active),
  .modulator_output_oe(modulator_output_oe), .conversion_done_pin_oe(conversion_done_pin_oe),
  .ratio_code(ratio_code), .oversampling_ratio(oversampling_ratio),
  .gain_code(gain_code), .ch0_gain(ch0_gain));

//--- ims_regs.vh
// constants for the interface mode and pin strap configuration block
`ifndef IMS_REGS_VH
`define IMS_REGS_VH

// timing
`define IMS_CLK_PERIOD_PS     32'd10000
`define IMS_WATCH_PS          32'd3600000
`define IMS_WATCH_CYCLES      (`IMS_WATCH_PS / `IMS_CLK_PERIOD_PS)
`define IMS_POR_WAIT          2'h2

// reset values
`define IMS_EXT_CLK_SEL_RST   1'b1
`define IMS_MODE_RST          1'b0
`define IMS_RATIO_RST         2'h0
`define IMS_BOOST_RST         1'b0
`define IMS_GAIN_RST          2'h0
`define IMS_CNT_RST           2'h0

// interface mode encoding
`define IMS_MODE_SPI          1'b0
`define IMS_MODE_TWO_WIRE     1'b1

// synchroniser bit positions
`define IMS_SY_SELECT         3'd0
`define IMS_SY_RESET          3'd1
`define IMS_SY_SDI            3'd2
`define IMS_SY_CS             3'd3
`define IMS_SY_OSCILLATOR_INPUT_PIN           3'd4
`define IMS_SY_DONE           3'd5
`define IMS_SY_SCK            3'd6
`define IMS_SY_WIDTH          7

// frame layout
`define IMS_SYNC_BYTE         8'ha5
`define IMS_FRAME_LONG        7'd80
`define IMS_FRAME_SHORT       7'd64
`define IMS_WORD_WIDTH        64
`define IMS_FIFO_DEPTH        16

`endif

//--- tb_ims_mode_config.sv
// self-checking bench for mode selection, strap latching and framer
`timescale 1ns/1ps
module tb_ims_mode_config;
  logic clock, rst_n, ext_clk_sel_write, ext_clk_sel_value, interface_select_pin;
  logic reset_pin_n, sdi_pin, cs_pin_n, oscillator_input_pin, conversion_done_pin_in;
  logic spi_done_n, result_valid, hold_high, serial_clock_level, external_clock_select;
  logic conversion_done_pin_out, conversion_done_pin_oe, result_ready, sdo, sdo_oe;
  logic two_wire_mode, force_defaults, boost_full, frame_active, core_reset;
  logic [1:0] modulator_data, modulator_output_pins, modulator_output_oe;
  logic [1:0] ratio_code, gain_code, frame_count_bits;
  logic [9:0] oversampling_ratio;
  logic [5:0] ch0_gain;
  logic [23:0] ch0, ch1;
  logic [15:0] crc;
  logic [79:0] frame_bits;
  logic [6:0] frame_len;
  logic [7:0] frame_total;
  logic [4:0] s;
  int bad_count, checks_done, i, n;
  ims_mode_config dut_u (.clock(clock), .rst_n(rst_n), .ext_clk_sel_write(ext_clk_sel_write),
    .ext_clk_sel_value(ext_clk_sel_value), .external_clock_select(external_clock_select),
    .interface_select_pin(interface_select_pin), .reset_pin_n(reset_pin_n), .sdi_pin(sdi_pin),
    .cs_pin_n(cs_pin_n), .oscillator_input_pin(oscillator_input_pin),
    .conversion_done_pin_in(conversion_done_pin_in), .conversion_done_pin_out(conversion_done_pin_out),
    .conversion_done_pin_oe(conversion_done_pin_oe), .serial_clock_level(serial_clock_level),
    .spi_ratio_code(2'h2), .spi_boost(1'b1), .spi_gain_code(2'h3), .spi_done_n(spi_done_n),
    .modulator_data(modulator_data), .modulator_output_pins(modulator_output_pins),
    .modulator_output_oe(modulator_output_oe), .result_valid(result_valid),
    .result_ready(result_ready), .result_ch0(ch0), .result_ch1(ch1), .result_crc(crc),
    .sdo(sdo), .sdo_oe(sdo_oe), .two_wire_mode(two_wire_mode), .force_defaults(force_defaults),
    .ratio_code(ratio_code), .oversampling_ratio(oversampling_ratio), .boost_full(boost_full),
    .gain_code(gain_code), .ch0_gain(ch0_gain), .frame_count_bits(frame_count_bits),
    .frame_active(frame_active), .core_reset(core_reset));
  ims_host_model host_u (.clock(clock), .rst_n(rst_n), .hold_high(hold_high),
    .serial_clock_level(serial_clock_level), .sdo(sdo), .frame_active(frame_active),
    .frame_bits(frame_bits), .frame_len(frame_len), .frame_total(frame_total));
  task check(input [79:0] seen, input [79:0] exp, input [8*10-1:0] what);
    checks_done++;
    if (seen !== exp) begin
      bad_count++;
      $display("CHECK FAILED %0s expected %0h seen %0h", what, exp, seen);
    end
  endtask
  task summarize;
    $display("checks %0d mismatches %0d", checks_done, bad_count);
    if (bad_count == 0 && checks_done > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  task set_straps(input [4:0] v);
    {conversion_done_pin_in, oscillator_input_pin, cs_pin_n, sdi_pin, reset_pin_n} = v;
  endtask
  // select and straps settle well before the reset ends
  task por(input sel, input [4:0] v);
    @(negedge clock);
    rst_n = 0;
    interface_select_pin = sel;
    set_straps(v);
    repeat (8) @(negedge clock);
    rst_n = 1;
    repeat (8) @(negedge clock);
  endtask
  task wr_ext(input v);
    ext_clk_sel_value = v;
    ext_clk_sel_write = 1;
    @(negedge clock);
    ext_clk_sel_write = 0;
    @(negedge clock);
  endtask
  task chk_cfg(input [4:0] v);
    check(two_wire_mode, 1'b1, "mode");
    check(force_defaults, 1'b1, "defaults");
    check(ratio_code, v[1:0], "ratio");
    check(oversampling_ratio, 10'h040 << v[1:0], "osr");
    check(boost_full, v[2], "boost");
    check(gain_code, v[4:3], "gain");
    check(ch0_gain, (v[4:3] == 2'h0) ? 6'h01 : 6'h04 << v[4:3], "gain val");
  endtask
  task push(input [23:0] a, input [23:0] b, input [15:0] c);
    @(negedge clock);
    result_valid = 1;
    {ch0, ch1, crc} = {a, b, c};
    while (result_ready !== 1'b1) @(negedge clock);
    @(negedge clock);
    result_valid = 0;
  endtask
  task wait_frames(input [7:0] want);
    int k;
    k = 0;
    while (frame_total !== want && k < 3000) begin
      @(negedge clock);
      k++;
    end
    check(frame_total, want, "frames");
  endtask
  initial begin
    clock = 0;
    forever #5 clock = ~clock;
  end
  initial begin
    #200000;
    bad_count++;
    summarize;
  end
  initial begin
    {rst_n, ext_clk_sel_write, ext_clk_sel_value, result_valid, hold_high} = 5'h00;
    {interface_select_pin, spi_done_n, modulator_data, ch0, ch1, crc} = 0;
    set_straps(5'h01);
    por(1'b0, 5'h01);
    check(external_clock_select, 1'b1, "extclk");
    check(two_wire_mode, 1'b0, "spi mode");
    check(result_ready, 1'b0, "spi ready");
    wr_ext(1'b0);
    check(external_clock_select, 1'b0, "extclk wr");
    wr_ext(1'b1);
    interface_select_pin = 1;
    for (i = 0; i < 2; i++) begin
      modulator_data = i ? 2'h2 : 2'h1;
      spi_done_n = i[0];
      repeat (3) @(negedge clock);
      check(two_wire_mode, 1'b0, "no relatch");
      check(modulator_output_pins, modulator_data, "mdat");
      check(modulator_output_oe, 2'h3, "mdat oe");
      check(conversion_done_pin_out, spi_done_n, "done");
    end
    $display("test spi done");
    set_straps(5'h1e);
    repeat (6) @(negedge clock);
    reset_pin_n = 1;
    repeat (8) @(negedge clock);
    chk_cfg(5'h1f);
    check(external_clock_select, 1'b1, "extclk hr");
    for (i = 0; i < 4; i++) begin
      s = {i[1:0], i[0], ~i[1:0]};
      por(1'b1, s);
      chk_cfg(s);
    end
    $display("test straps done");
    por(1'b1, 5'h09);
    for (i = 0; i < 2; i++) begin
      push(24'h123456 + i, 24'habcdef, 16'h5a3c);
      wait_frames(i + 1);
      check(frame_len, 7'h50, "len");
      check(frame_bits, {8'ha5, 2'h1, 1'b0, 2'h1, i[1:0], 1'b0, 24'(24'h123456 + i), 24'habcdef,
        16'h5a3c}, "frame");
      check(frame_count_bits, i + 1, "cnt");
    end
    set_straps(5'h10);
    interface_select_pin = 0;
    repeat (4) @(negedge clock);
    interface_select_pin = 1;
    repeat (6) @(negedge clock);
    chk_cfg(5'h10);
    check(sdo, 1'b0, "idle sdo");
    push(24'h876543, 24'h0f1e2d, 16'hc3c3);
    wait_frames(3);
    check(frame_len, 7'h40, "short len");
    check(frame_bits[63:0], {8'ha5, 2'h0, 1'b0, 2'h2, 2'h2, 1'b0, 16'h8765, 16'h0f1e, 16'hc3c3},
      "short");
    $display("test frames done");
    n = 0;
    @(negedge clock);
    result_valid = 1;
    while (result_ready === 1'b1 && n < 40) begin
      n++;
      @(negedge clock);
    end
    result_valid = 0;
    check(n >= 16 && n < 40, 1'b1, "fill");
    wait_frames(3 + n);
    check(result_ready, 1'b1, "drained");
    $display("test fifo done");
    set_straps(5'h01);
    interface_select_pin = 0;
    hold_high = 1;
    n = 0;
    repeat (400) begin
      @(negedge clock);
      n += core_reset;
    end
    hold_high = 0;
    repeat (6) @(negedge clock);
    check(n > 0, 1'b1, "watchdog");
    check(two_wire_mode, 1'b0, "wd spi");
    check(sdo_oe, 1'b0, "wd sdo oe");
    $display("test watchdog done");
    summarize;
  end
endmodule // tb_ims_mode_config
